// File: rtl/ddcdb_params.svh
// register map, reset values and widths for the dual band down converter
`ifndef DDCDB_PARAMS_SVH
`define DDCDB_PARAMS_SVH
`define DDCDB_ADDR_W 5
`define DDCDB_OFS_CTRL 5'h00
`define DDCDB_OFS_NCO0 5'h04
`define DDCDB_OFS_NCO1 5'h08
`define DDCDB_OFS_STAT 5'h0C
`define DDCDB_OFS_ACT0 5'h10
`define DDCDB_OFS_ACT1 5'h14
`define DDCDB_CTRL_RST 32'h0000_0000
`define DDCDB_NCO_RST 32'h0000_0000
`define DDCDB_CTRL_BITS 17
`define DDCDB_ADC_W 16
`define DDCDB_DSP_W 20
`define DDCDB_ACC_W 25
`define DDCDB_NCO_W 32
`define DDCDB_BANDS 2
`define DDCDB_DEC_MAX 3'h4
`define DDCDB_RES_MIN 14
`define DDCDB_RES_MAX 3'h6
`define DDCDB_BIT_CNT_W 5
`endif

// File: rtl/ddcdb_pkg.sv
// types shared by the dual band down converter
`include "ddcdb_params.svh"
package ddcdb_pkg;
    // control register layout, lsb first from the bottom of the struct
    typedef struct packed {
        logic restart;     // bit 16, any change reloads the oscillators
        logic [2:0] res;   // bits 15:13, output bits = 14 + res, res above 6 counts as 6
        logic [2:0] unused;// bits 12:10
        logic inv1;        // bit 9, second band negative rotation
        logic inv0;        // bit 8, first band negative rotation
        logic gain3;       // bit 7
        logic gain6;       // bit 6
        logic [2:0] dec;   // bits 5:3, factor = 2 << dec, dec above 4 counts as 4
        logic dual;        // bit 2
        logic real_mode;   // bit 1
        logic enable;      // bit 0
    } ddcdb_ctrl_t;

    // one decimated output word
    typedef struct packed {
        logic [`DDCDB_DSP_W-1:0] i;
        logic [`DDCDB_DSP_W-1:0] q;
    } ddcdb_word_t;
endpackage : ddcdb_pkg

// File: rtl/ddcdb_top.sv
// dual band digital down converter with avalon registers and serial lanes
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ddcdb_params.svh"
module ddcdb_top
    import ddcdb_pkg::*;
(
    // sampling clock domain
    input wire logic i_clk,
    input wire logic i_srst,
    // converter samples
    input wire logic [`DDCDB_ADC_W-1:0] i_smp,
    input wire logic i_smp_vld,
    input wire logic i_sync,
    // avalon-mm slave
    input wire logic [`DDCDB_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // serial link domain
    input wire logic i_lclk,
    output logic [1:0] o_first_lane_pair,
    output logic o_first_frame,
    output logic [1:0] o_second_band_lane_pair,
    output logic o_second_frame
);
    localparam int DW = `DDCDB_DSP_W;
    localparam int AW = `DDCDB_ACC_W;

    ddcdb_ctrl_t ctrl_ff;
    logic [31:0] nco_ff [`DDCDB_BANDS];
    logic [31:0] act_ff [`DDCDB_BANDS];
    logic [`DDCDB_BANDS-1:0] ovr_ff;
    logic [`DDCDB_BANDS-1:0] ovr_evt;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic restart_d_ff;
    logic sync_s1_ff, sync_s2_ff, sync_s3_ff;
    logic reload;
    logic req;
    logic [31:0] wmask;
    logic [31:0] rd_mux;

    // bus handshake: one wait cycle, answer on the second edge
    assign req = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~ack_ff;
    assign o_avs_readdata = rdata_ff;
    assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            ack_ff <= 1'b0;
        else
            ack_ff <= req & ~ack_ff;
    end

    // read mux, unmapped offsets read zero
    always_comb
    begin
        case (i_avs_address)
            `DDCDB_OFS_CTRL: rd_mux = {15'h0000, ctrl_ff};
            `DDCDB_OFS_NCO0: rd_mux = nco_ff[0];
            `DDCDB_OFS_NCO1: rd_mux = nco_ff[1];
            `DDCDB_OFS_STAT: rd_mux = {30'h0000_0000, ovr_ff};
            `DDCDB_OFS_ACT0: rd_mux = act_ff[0];
            `DDCDB_OFS_ACT1: rd_mux = act_ff[1];
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            rdata_ff <= 32'h0000_0000;
        else if (i_avs_read & ~ack_ff)
            rdata_ff <= rd_mux;
    end

    // control and frequency registers, writes land on the wait cycle
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            ctrl_ff <= ddcdb_ctrl_t'(`DDCDB_CTRL_RST);
            nco_ff[0] <= `DDCDB_NCO_RST;
            nco_ff[1] <= `DDCDB_NCO_RST;
        end
        else if (i_avs_write & ~ack_ff)
        begin
            case (i_avs_address)
                `DDCDB_OFS_CTRL: ctrl_ff <= ddcdb_ctrl_t'(
                    (i_avs_writedata[`DDCDB_CTRL_BITS-1:0]
                     & wmask[`DDCDB_CTRL_BITS-1:0])
                    | (ctrl_ff & ~wmask[`DDCDB_CTRL_BITS-1:0]));
                `DDCDB_OFS_NCO0: nco_ff[0] <= (i_avs_writedata & wmask)
                                              | (nco_ff[0] & ~wmask);
                `DDCDB_OFS_NCO1: nco_ff[1] <= (i_avs_writedata & wmask)
                                              | (nco_ff[1] & ~wmask);
                default: ;
            endcase
        end
    end

    // overrun flags: write one clears, a new overrun wins over the clear
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            ovr_ff <= 2'h0;
        else if (i_avs_write & ~ack_ff & (i_avs_address == `DDCDB_OFS_STAT))
            ovr_ff <= (ovr_ff & ~(i_avs_writedata[1:0] & wmask[1:0]))
                      | ovr_evt;
        else
            ovr_ff <= ovr_ff | ovr_evt;
    end

    // sync pin is asynchronous; the second and third stages feed the edge check
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            sync_s1_ff <= 1'b0;
            sync_s2_ff <= 1'b0;
            sync_s3_ff <= 1'b0;
            restart_d_ff <= 1'b0;
        end
        else
        begin
            sync_s1_ff <= i_sync;
            sync_s2_ff <= sync_s1_ff;
            sync_s3_ff <= sync_s2_ff;
            restart_d_ff <= ctrl_ff.restart;
        end
    end
    // either edge of restart bit or sync pin
    assign reload = (restart_d_ff ^ ctrl_ff.restart)
                    | (sync_s2_ff ^ sync_s3_ff);

    // quarter-step cosine table in Q15, 16 phases per turn
    function automatic logic signed [15:0] cos_lut(input logic [3:0] idx);
        logic signed [15:0] v;
        case (idx[2:0])
            3'h0: v = 16'sh7FFF;
            3'h1: v = 16'sh7642;
            3'h2: v = 16'sh5A82;
            3'h3: v = 16'sh30FC;
            3'h4: v = 16'sh0000;
            3'h5: v = -16'sh30FC;
            3'h6: v = -16'sh5A82;
            3'h7: v = -16'sh7642;
            default: v = 16'sh0000;
        endcase
        cos_lut = idx[3] ? -v : v;
    endfunction : cos_lut
    // clip a 22-bit value into the 20-bit datapath
    function automatic logic [DW-1:0] sat20(input logic signed [DW+1:0] x);
        logic [DW-1:0] r;
        r = x[DW-1:0];
        if (x > $signed({3'h0, {(DW-1){1'b1}}}))
            r = {1'b0, {(DW-1){1'b1}}};
        else if (x < $signed({3'h7, {(DW-1){1'b0}}}))
            r = {1'b1, {(DW-1){1'b0}}};
        sat20 = r;
    endfunction : sat20
    // gain then truncation to the output resolution
    function automatic logic [DW-1:0] fmt(input logic signed [DW-1:0] x,
                                          input ddcdb_ctrl_t c);
        logic signed [DW+1:0] w;
        logic [2:0] r;
        w = {{2{x[DW-1]}}, x};
        if (c.gain6 & ~c.real_mode)
            w = w <<< 1;
        if (c.gain3 & c.real_mode)
            w = w + (w >>> 2) + (w >>> 3) + (w >>> 5);
        r = (c.res > `DDCDB_RES_MAX) ? `DDCDB_RES_MAX : c.res;
        // drop low bits below the output width
        fmt = sat20(w) & ({DW{1'b1}} << (`DDCDB_RES_MAX - r));
    endfunction : fmt
    // per-band handshake toward the link domain
    logic [`DDCDB_BANDS-1:0] req_tog_ff;
    logic [`DDCDB_BANDS-1:0] ack_s1_ff, ack_s2_ff;
    logic [`DDCDB_BANDS-1:0] lack_tog_ff;
    ddcdb_word_t hold_ff [`DDCDB_BANDS];
    logic lrst_s1_ff, lrst_ff;
    logic [1:0] lane_ff [`DDCDB_BANDS];
    logic [`DDCDB_BANDS-1:0] frame_ff;
    // reset carried into the link domain as a level
    always_ff @(posedge i_lclk)
    begin
        lrst_s1_ff <= i_srst;
        lrst_ff <= lrst_s1_ff;
    end
    genvar g;
    generate
        for (g = 0; g < `DDCDB_BANDS; g++)
        begin : g_band
            logic [31:0] ph_ff;
            logic [4:0] cnt_ff;
            logic signed [AW-1:0] acc_i_ff, acc_q_ff;
            logic signed [DW-1:0] mix_i, mix_q;
            logic signed [AW-1:0] sum_i, sum_q;
            logic signed [31:0] prod_i, prod_q;
            logic signed [15:0] s16;
            logic [4:0] last;
            logic in_vld, dump, inv, band_on;
            ddcdb_word_t word;
            logic tg_s1_ff, tg_s2_ff, tg_s3_ff;
            logic busy_ff;
            logic [`DDCDB_BIT_CNT_W-1:0] bit_ff;
            logic [DW-1:0] sh_i_ff, sh_q_ff;
            logic [2:0] dcl;
            // multiplexer: band one only in dual mode
            assign band_on = (g == 0) ? 1'b1 : (ctrl_ff.enable & ctrl_ff.dual);
            assign in_vld = i_smp_vld & band_on;
            assign inv = (g == 0) ? ctrl_ff.inv0 : ctrl_ff.inv1;
            assign s16 = i_smp;
            assign prod_i = s16 * cos_lut(ph_ff[31:28]);
            assign prod_q = s16 * cos_lut(ph_ff[31:28] - 4'h4);
            always_comb
            begin
                if (ctrl_ff.real_mode)
                begin
                    mix_i = {s16, 4'h0};
                    mix_q = {DW{1'b0}};
                end
                else
                begin
                    // keep 20 bits from the product
                    mix_i = prod_i[30:11];
                    mix_q = inv ? -prod_q[30:11] : prod_q[30:11];
                end
            end
            // signed phase step, wraps modulo 2^32
            always_ff @(posedge i_clk)
            begin
                if (i_srst)
                begin
                    act_ff[g] <= `DDCDB_NCO_RST;
                    ph_ff <= 32'h0000_0000;
                end
                // apply the written word, restart phase
                else if (reload)
                begin
                    act_ff[g] <= nco_ff[g];
                    ph_ff <= 32'h0000_0000;
                end
                else if (in_vld & ctrl_ff.enable & ~ctrl_ff.real_mode)
                    ph_ff <= ph_ff + act_ff[g];
            end
            // factor 2 << dec, clamped so count and shift agree
            assign dcl = (ctrl_ff.dec > `DDCDB_DEC_MAX) ? `DDCDB_DEC_MAX
                                                         : ctrl_ff.dec;
            assign last = 5'h1F >> (`DDCDB_DEC_MAX - dcl);
            assign sum_i = acc_i_ff + AW'(mix_i);
            assign sum_q = acc_q_ff + AW'(mix_q);
            assign dump = in_vld & ctrl_ff.enable & (cnt_ff == last);
            // boxcar low-pass at zero frequency, then drop samples
            // counters and sums cleared at reset, a dump restarts them
            always_ff @(posedge i_clk)
            begin
                if (i_srst | ~ctrl_ff.enable | dump)
                begin
                    cnt_ff <= 5'h00;
                    acc_i_ff <= '0;
                    acc_q_ff <= '0;
                end
                else if (in_vld)
                begin
                    cnt_ff <= cnt_ff + 5'h01;
                    acc_i_ff <= sum_i;
                    acc_q_ff <= sum_q;
                end
            end
            // disabled: each first band sample goes out undecimated unless the previous word is still pending, the second band sends nothing
            always_comb
            begin
                if (~ctrl_ff.enable)
                begin
                    word.i = fmt({s16, 4'h0}, ctrl_ff);
                    word.q = {DW{1'b0}};
                end
                else
                begin
                    word.i = fmt(DW'(sum_i >>> (dcl + 3'h1)), ctrl_ff);
                    word.q = ctrl_ff.real_mode ? {DW{1'b0}} :
                        fmt(DW'(sum_q >>> (dcl + 3'h1)), ctrl_ff);
                end
            end
            // hand a word over unless the previous one is still pending
            assign ovr_evt[g] = (ctrl_ff.enable ? dump : in_vld)
                                & (req_tog_ff[g] != ack_s2_ff[g]);
            always_ff @(posedge i_clk)
            begin
                if (i_srst)
                begin
                    req_tog_ff[g] <= 1'b0;
                    hold_ff[g] <= '0;
                    ack_s1_ff[g] <= 1'b0;
                    ack_s2_ff[g] <= 1'b0;
                end
                else
                begin
                    ack_s1_ff[g] <= lack_tog_ff[g];
                    ack_s2_ff[g] <= ack_s1_ff[g];
                    if ((ctrl_ff.enable ? dump : in_vld)
                        & (req_tog_ff[g] == ack_s2_ff[g]))
                    begin
                        req_tog_ff[g] <= ~req_tog_ff[g];
                        hold_ff[g] <= word;
                    end
                end
            end
            // link side: take the held word, shift it out msb first
            always_ff @(posedge i_lclk)
            begin
                if (lrst_ff)
                begin
                    tg_s1_ff <= 1'b0;
                    tg_s2_ff <= 1'b0;
                    tg_s3_ff <= 1'b0;
                    lack_tog_ff[g] <= 1'b0;
                    busy_ff <= 1'b0;
                    bit_ff <= '0;
                    sh_i_ff <= '0;
                    sh_q_ff <= '0;
                    lane_ff[g] <= 2'h0;
                    frame_ff[g] <= 1'b0;
                end
                else
                begin
                    tg_s1_ff <= req_tog_ff[g];
                    tg_s2_ff <= tg_s1_ff;
                    if (~busy_ff & (tg_s2_ff ^ tg_s3_ff))
                    begin
                        tg_s3_ff <= tg_s2_ff;
                        lack_tog_ff[g] <= tg_s2_ff;
                        busy_ff <= 1'b1;
                        bit_ff <= 5'(DW - 1);
                        sh_i_ff <= hold_ff[g].i << 1;
                        sh_q_ff <= hold_ff[g].q << 1;
                        lane_ff[g] <= {hold_ff[g].q[DW-1], hold_ff[g].i[DW-1]};
                        frame_ff[g] <= 1'b1;
                    end
                    else if (busy_ff & (bit_ff != '0))
                    begin
                        bit_ff <= bit_ff - 5'h01;
                        sh_i_ff <= sh_i_ff << 1;
                        sh_q_ff <= sh_q_ff << 1;
                        lane_ff[g] <= {sh_q_ff[DW-1], sh_i_ff[DW-1]};
                    end
                    else
                    begin
                        busy_ff <= 1'b0;
                        lane_ff[g] <= 2'h0;
                        frame_ff[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // lane pairs: lane 0 carries i, lane 1 carries q
    assign o_first_lane_pair = lane_ff[0];
    assign o_first_frame = frame_ff[0];
    // second band on its own pair
    assign o_second_band_lane_pair = lane_ff[1];
    assign o_second_frame = frame_ff[1];
endmodule : ddcdb_top

// File: verification/ddcdb_top_sva.sv
// port checker for the dual band down converter
`timescale 1ns/1ps
`include "ddcdb_params.svh"
module ddcdb_top_sva
    import ddcdb_pkg::*;
(
    // sampling domain
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [`DDCDB_ADC_W-1:0] i_smp,
    input wire logic i_smp_vld,
    input wire logic i_sync,
    // register bus
    input wire logic [`DDCDB_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // link domain
    input wire logic i_lclk,
    input wire logic [1:0] o_first_lane_pair,
    input wire logic o_first_frame,
    input wire logic [1:0] o_second_band_lane_pair,
    input wire logic o_second_frame
);
    logic [4:0] len0_ff;
    logic [4:0] len1_ff;

    // frame lengths, cleared while low so a long frame shows at its end
    always_ff @(posedge i_lclk)
    begin
        len0_ff <= o_first_frame ? len0_ff + 5'h01 : 5'h00;
        len1_ff <= o_second_frame ? len1_ff + 5'h01 : 5'h00;
    end

    wait_one_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=>
        !o_avs_waitrequest) else $error("wait longer than one cycle");
    wait_first_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_avs_read || i_avs_write) && !$past(i_avs_read || i_avs_write)
        |-> o_avs_waitrequest) else $error("no wait on new request");
    idle_free_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
        else $error("wait without request");
    rdata_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_avs_read |=> $stable(o_avs_readdata))
        else $error("read data moved without read");
    rst_rdata_a: assert property (@(posedge i_clk)
        i_srst |=> o_avs_readdata == 32'h0) else $error("read data not clear");
    rst_link_a: assert property (@(posedge i_lclk)
        i_srst [*6] |-> !o_first_frame && !o_second_frame &&
        o_first_lane_pair == 2'h0) else $error("link busy in reset");
    frame_len0_a: assert property (@(posedge i_lclk) disable iff (i_srst)
        $fell(o_first_frame) |-> len0_ff == 5'h14)
        else $error("first frame length wrong");
    frame_len1_a: assert property (@(posedge i_lclk) disable iff (i_srst)
        $fell(o_second_frame) |-> len1_ff == 5'h14)
        else $error("second frame length wrong");
    lane_idle0_a: assert property (@(posedge i_lclk) disable iff (i_srst)
        !o_first_frame |-> o_first_lane_pair == 2'h0)
        else $error("first lanes busy outside frame");
    lane_idle1_a: assert property (@(posedge i_lclk) disable iff (i_srst)
        !o_second_frame |-> o_second_band_lane_pair == 2'h0)
        else $error("second lanes busy outside frame");

    // main scenarios
    rd_c: cover property (@(posedge i_clk) i_avs_read && !o_avs_waitrequest);
    wr_c: cover property (@(posedge i_clk) i_avs_write && !o_avs_waitrequest);
    f0_c: cover property (@(posedge i_lclk) $fell(o_first_frame));
    f1_c: cover property (@(posedge i_lclk) $fell(o_second_frame));
endmodule : ddcdb_top_sva

bind ddcdb_top ddcdb_top_sva i_ddcdb_top_sva (.i_clk, .i_srst, .i_smp,
    .i_smp_vld, .i_sync, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
    .o_avs_waitrequest, .i_lclk, .o_first_lane_pair, .o_first_frame,
    .o_second_band_lane_pair, .o_second_frame);

// File: verification/ddcdb_lvds_rx.sv
// serial receiver model rebuilding words from one lane pair
`timescale 1ns/1ps
`include "ddcdb_params.svh"
module ddcdb_lvds_rx
    import ddcdb_pkg::*;
(
    // link side
    input wire logic i_lclk,
    input wire logic [1:0] i_lanes,
    input wire logic i_frame,
    // captured words
    output ddcdb_word_t o_word,
    output logic [15:0] o_count
);
    ddcdb_word_t shift_ff;
    logic frame_ff;

    initial
    begin
        shift_ff = '0;
        frame_ff = 1'b0;
        o_word = '0;
        o_count = 16'h0000;
    end

    // twenty bits msb first
    // word latched at frame end, so a short frame keeps stale high bits
    always @(posedge i_lclk)
    begin
        frame_ff <= i_frame;
        if (i_frame)
            shift_ff <= {shift_ff.i[`DDCDB_DSP_W-2:0], i_lanes[0],
                shift_ff.q[`DDCDB_DSP_W-2:0], i_lanes[1]};
        else if (frame_ff)
        begin
            o_word <= shift_ff;
            o_count <= o_count + 16'h0001;
        end
    end
endmodule : ddcdb_lvds_rx

// File: verification/tb.sv
// register and stream bench for the dual band down converter
`timescale 1ns/1ps
`include "ddcdb_params.svh"
module tb
    import ddcdb_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_lclk = 1'b0;
    logic i_srst = 1'b1;
    logic [`DDCDB_ADC_W-1:0] i_smp = '0;
    logic i_smp_vld = 1'b0;
    logic i_sync = 1'b0;
    logic [`DDCDB_ADDR_W-1:0] i_avs_address = '0;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = '0;
    logic [3:0] i_avs_byteenable = 4'hF;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic [1:0] o_first_lane_pair;
    logic o_first_frame;
    logic [1:0] o_second_band_lane_pair;
    logic o_second_frame;
    ddcdb_word_t w0;
    ddcdb_word_t w1;
    logic [15:0] n0;
    logic [15:0] n1;
    logic [15:0] b0;
    logic [15:0] b1;
    logic [31:0] rd;
    ddcdb_ctrl_t c;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    logic [4:0] addrs [7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14,
        5'h18};

    ddcdb_top i_ddcdb_top (.i_clk, .i_srst, .i_smp, .i_smp_vld, .i_sync,
        .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
        .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_lclk,
        .o_first_lane_pair, .o_first_frame, .o_second_band_lane_pair,
        .o_second_frame);
    ddcdb_lvds_rx i_ddcdb_lvds_rx_0 (.i_lclk, .i_lanes(o_first_lane_pair),
        .i_frame(o_first_frame), .o_word(w0), .o_count(n0));
    ddcdb_lvds_rx i_ddcdb_lvds_rx_1 (.i_lclk,
        .i_lanes(o_second_band_lane_pair), .i_frame(o_second_frame),
        .o_word(w1), .o_count(n1));

    // clocks, link offset so the edges never line up
    initial forever #20 i_clk = ~i_clk;
    initial
    begin
        #7;
        forever #32 i_lclk = ~i_lclk;
    end

    // hang guard, the tests need well under a fifth of this
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            fails = fails + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (fails == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    task automatic chk(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [31:0] d, input logic [3:0] be);
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_byteenable <= be;
        i_avs_read <= !wr;
        i_avs_write <= wr;
        // no limit of its own, the hang guard ends a stuck wait
        do
        begin
            @(posedge i_clk);
        end
        while (o_avs_waitrequest !== 1'b0);
        rd = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask : bus

    task automatic rchk(input string name, input logic [4:0] a,
        input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(name, rd, exp);
    endtask : rchk

    task automatic wctrl(input ddcdb_ctrl_t v);
        bus(1'b1, `DDCDB_OFS_CTRL, 32'(v), 4'hF);
    endtask : wctrl

    // n single valid samples, one every gap cycles, then let the link drain
    task automatic feed(input logic [15:0] x, input int n, input int gap);
        b0 = n0;
        b1 = n1;
        repeat (n)
        begin
            @(posedge i_clk);
            i_smp <= x;
            i_smp_vld <= 1'b1;
            @(posedge i_clk);
            i_smp_vld <= 1'b0;
            repeat (gap - 2) @(posedge i_clk);
        end
        repeat (150) @(posedge i_clk);
    endtask : feed

    initial
    begin
        repeat (20) @(posedge i_clk);
        i_srst <= 1'b0;
        bus(1'b1, 5'h18, 32'hFFFF_FFFF, 4'hF);
        for (int k = 0; k < 7; k++)
            rchk("reg", addrs[k], 32'h0);
        bus(1'b1, `DDCDB_OFS_NCO0, 32'h1234_5678, 4'hF);
        rchk("act0 held", `DDCDB_OFS_ACT0, 32'h0);
        c = '0;
        c.restart = 1'b1;
        wctrl(c);
        rchk("act0 new", `DDCDB_OFS_ACT0, 32'h1234_5678);
        bus(1'b1, `DDCDB_OFS_NCO1, 32'h8000_0000, 4'hF);
        rchk("act1 held", `DDCDB_OFS_ACT1, 32'h0);
        @(posedge i_clk);
        i_sync <= 1'b1;
        repeat (6) @(posedge i_clk);
        rchk("act1 sync", `DDCDB_OFS_ACT1, 32'h8000_0000);
        rchk("act0 kept", `DDCDB_OFS_ACT0, 32'h1234_5678);
        bus(1'b1, `DDCDB_OFS_NCO1, 32'hFFFF_FFFF, 4'h1);
        rchk("nco1 lanes", `DDCDB_OFS_NCO1, 32'h8000_00FF);
        // zero frequency for real mode, reloaded by the restart change
        bus(1'b1, `DDCDB_OFS_NCO0, 32'h0, 4'hF);
        c = '0;
        c.enable = 1'b1;
        c.real_mode = 1'b1;
        c.res = 3'h6;
        for (int d = 0; d < 5; d++)
        begin
            c.dec = 3'(d);
            wctrl(c);
            feed(16'h03E8, 8 << d, 32 >> d);
            chk("real words", 32'(n0 - b0), 32'h4);
            chk("real i", 32'(w0.i), 32'h3E80);
            chk("real q", 32'(w0.q), 32'h0);
            chk("band1 off", 32'(n1 - b1), 32'h0);
        end
        c.dec = 3'h0;
        // third pass adds the 3 dB gain, 16016 times 1.40625
        for (int r = 0; r < 3; r++)
        begin
            c.res = r ? 3'h6 : 3'h0;
            c.gain3 = (r == 2);
            wctrl(c);
            feed(16'h03E9, 8, 32);
            chk("trunc i", 32'(w0.i), r == 2 ? 32'h57FA :
                r ? 32'h3E90 : 32'h3E80);
        end
        c = '0;
        c.enable = 1'b1;
        c.dual = 1'b1;
        c.res = 3'h6;
        c.dec = 3'h3;
        for (int g = 0; g < 2; g++)
        begin
            c.gain6 = g[0];
            wctrl(c);
            feed(16'h03E8, 32, 16);
            chk("cplx i", 32'(w0.i), g ? 32'h7CFE : 32'h3E7F);
            chk("cplx q", 32'(w0.q), 32'h0);
            chk("band1 words", 32'(n1 - b1), 32'h2);
            chk("band1 i", 32'($signed(w1.i) < 64 && $signed(w1.i) > -64),
                32'h1);
        end
        // both bands at one sixteenth turn, only band0 inverted, gain6 on
        bus(1'b1, `DDCDB_OFS_NCO0, 32'h1000_0000, 4'hF);
        bus(1'b1, `DDCDB_OFS_NCO1, 32'h1000_0000, 4'hF);
        c.dec = 3'h0;
        c.inv0 = 1'b1;
        c.restart = 1'b1;
        wctrl(c);
        feed(16'h03E8, 8, 32);
        chk("inv q", 32'(w0.q), 32'h000F_BBE4);
        chk("plain q", 32'(w1.q), 32'h0000_441C);
        wctrl('0);
        feed(16'h03E8, 4, 64);
        chk("bypass words", 32'(n0 - b0), 32'h4);
        chk("bypass band1", 32'(n1 - b1), 32'h0);
        rchk("no drops", `DDCDB_OFS_STAT, 32'h0);
        // bypass at one sample every two cycles outruns the link, then write one clears
        feed(16'h03E8, 4, 2);
        rchk("overrun", `DDCDB_OFS_STAT, 32'h1);
        bus(1'b1, `DDCDB_OFS_STAT, 32'h1, 4'hF);
        rchk("overrun clr", `DDCDB_OFS_STAT, 32'h0);
        end_of_test();
    end
endmodule : tb
